// ### pmic_irq_pkg.sv
// constants shared by the fault interrupt status and mask logic
package pmic_irq_pkg;

  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int WB_ADR_W = 18;
  localparam int WB_DAT_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int REG_W = 16;
  localparam int IDX_W = 16;

  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CHG_STATUS = 16'h4012;
  localparam logic [IDX_W-1:0] IDX_REG_STATUS = 16'h4013;
  localparam logic [IDX_W-1:0] IDX_CONV_STATUS = 16'h4014;
  localparam logic [IDX_W-1:0] IDX_CHG_MASK = 16'h401a;
  localparam logic [IDX_W-1:0] IDX_REG_MASK = 16'h401b;
  localparam logic [IDX_W-1:0] IDX_CONV_MASK = 16'h401c;
  localparam logic [IDX_W-1:0] IDX_PRIMARY = 16'h4020;

  // ------------------------------------------------------------
  // field positions inside the 16-bit registers
  // ------------------------------------------------------------
  localparam int CHG_LSB = 8;
  localparam int CHG_W = 8;
  localparam int REG_UV_LSB = 0;
  localparam int REG_UV_W = 10;
  localparam int CONV_UV_LSB = 0;
  localparam int CONV_UV_W = 4;
  localparam int CONV_HC_LSB = 8;
  localparam int CONV_HC_W = 2;

  // primary summary register bits
  localparam int PRI_CHG_BIT = 0;
  localparam int PRI_HC_BIT = 1;
  localparam int PRI_UV_BIT = 2;

  // ------------------------------------------------------------
  // mask reset values: every implemented mask bit starts at one
  // ------------------------------------------------------------
  localparam logic [REG_W-1:0] CHG_MASK_RST = 16'hff00;
  localparam logic [REG_W-1:0] REG_MASK_RST = 16'h03ff;
  localparam logic [REG_W-1:0] CONV_MASK_RST = 16'h030f;
  localparam logic [REG_W-1:0] STATUS_RST = 16'h0000;

  // ------------------------------------------------------------
  // packing of all events into one flat vector
  // ------------------------------------------------------------
  localparam int EV_CHG_LSB = 0;
  localparam int EV_REG_LSB = 8;
  localparam int EV_UV_LSB = 18;
  localparam int EV_HC_LSB = 22;
  localparam int EV_W = 24;

endpackage : pmic_irq_pkg

// ### event_bank_if.sv
// carrier between the register logic and the sticky event bank
`timescale 1ns/1ps
`default_nettype none

interface event_bank_if #(
  parameter int W = 24
);
  logic [W-1:0] level;
  logic [W-1:0] clear;
  logic [W-1:0] flags;

  // bank side: takes synchronised levels and clears, shows flags
  modport bank (input level, input clear, output flags);
  // control side: drives levels and clears, reads flags
  modport ctrl (output level, output clear, input flags);
endinterface : event_bank_if

`default_nettype wire

// ### event_latch_bank.sv
// sticky rising-edge flags with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none

module event_latch_bank #(
  parameter int W = 24
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  event_bank_if.bank bank
);

  logic [W-1:0] prev_reg;
  logic [W-1:0] prev_next;
  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;
  logic [W-1:0] rise;

  // ------------------------------------------------------------
  // edge detect and sticky flags
  // ------------------------------------------------------------
  // set wins over clear in the same cycle
  always_comb begin
    rise = bank.level & ~prev_reg;
    prev_next = bank.level;
    flags_next = (flags_reg & ~bank.clear) | rise; // RULE_14
  end

  // register the bank
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prev_reg <= '0;
      flags_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      flags_reg <= flags_next;
    end
  end

  assign bank.flags = flags_reg; // RULE_02

endmodule // event_latch_bank

`default_nettype wire

// ### pmic_fault_interrupt_masking.sv
// fault interrupt status, mask and primary interrupt logic with wishbone slave
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01 - set mask bit blocks its primary interrupt
// RULE_02 - status latches regardless of mask value
// RULE_03 - all mask bits reset to one
// RULE_04 - writing one clears status, zero keeps
// RULE_05 - high-current interrupt from two converter sources
// RULE_06 - converter high-current flags at bits 9,8
// RULE_07 - high-current masks at bits 9,8
// RULE_08 - undervoltage interrupt from fourteen sources
// RULE_09 - regulator undervoltage flags and masks bits 9:0
// RULE_10 - converter undervoltage flags and masks bits 3:0
// RULE_11 - charger masks bits 15:8, hot first
// RULE_12 - charger flags bits 15:8, rising edge
// RULE_13 - primary high while any unmasked flag set
// RULE_14 - event beats clear in same cycle
module pmic_fault_interrupt_masking
  import pmic_irq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [WB_ADR_W-1:0] wb_adr_in,
  input wire logic [WB_SEL_W-1:0] wb_sel_in,
  input wire logic [WB_DAT_W-1:0] wb_dat_in,
  output logic [WB_DAT_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic [CHG_W-1:0] charger_event_in,
  input wire logic [REG_UV_W-1:0] regulator_uv_in,
  input wire logic [CONV_UV_W-1:0] converter_uv_in,
  input wire logic [CONV_HC_W-1:0] converter_hc_in,
  output logic charger_primary_irq_out,
  output logic high_current_primary_irq_out,
  output logic undervoltage_primary_irq_out,
  output logic irq_out
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // expand the two low byte enables to a 16-bit lane mask
  function automatic logic [REG_W-1:0] lane_mask(input logic [WB_SEL_W-1:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // merge write data into a mask register, implemented bits only
  function automatic logic [REG_W-1:0] mask_merge(
    input logic [REG_W-1:0] old_val,
    input logic [REG_W-1:0] wdata,
    input logic [REG_W-1:0] lanes,
    input logic [REG_W-1:0] valid
  );
    logic [REG_W-1:0] en;
    en = lanes & valid;
    mask_merge = (old_val & ~en) | (wdata & en);
  endfunction

  // true when the word address hits a register index
  function automatic logic hit(input logic [WB_ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
    hit = (adr[WB_ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [EV_W-1:0] raw_events;
  logic [EV_W-1:0] sync1_reg;
  logic [EV_W-1:0] sync1_next;
  logic [EV_W-1:0] sync2_reg;
  logic [EV_W-1:0] sync2_next;

  // pack detector levels, charger bit 7 is battery hot
  assign raw_events = {converter_hc_in, converter_uv_in, regulator_uv_in, charger_event_in};

  // two stages, only the second is read by logic
  always_comb begin
    sync1_next = raw_events;
    sync2_next = sync1_reg;
  end

  // register the synchronisers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ------------------------------------------------------------
  // sticky event bank
  // ------------------------------------------------------------
  event_bank_if #(.W(EV_W)) ev_if ();

  logic [EV_W-1:0] clear_vec;

  assign ev_if.level = sync2_reg;
  assign ev_if.clear = clear_vec;

  event_latch_bank #(
    .W(EV_W)
  ) u_bank (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .bank(ev_if.bank)
  );

  // unpack flags, rising edges latched inside the bank
  logic [CHG_W-1:0] charger_flags;
  logic [REG_UV_W-1:0] regulator_undervolt_flags;
  logic [CONV_UV_W-1:0] converter_undervolt_flags;
  logic conv1_overcurrent_flag;
  logic conv2_overcurrent_flag;

  assign charger_flags = ev_if.flags[EV_CHG_LSB +: CHG_W]; // RULE_12
  assign regulator_undervolt_flags = ev_if.flags[EV_REG_LSB +: REG_UV_W]; // RULE_09
  assign converter_undervolt_flags = ev_if.flags[EV_UV_LSB +: CONV_UV_W]; // RULE_10
  assign conv1_overcurrent_flag = ev_if.flags[EV_HC_LSB]; // RULE_06
  assign conv2_overcurrent_flag = ev_if.flags[EV_HC_LSB+1]; // RULE_06

  // status register images, reserved bits zero
  logic [REG_W-1:0] chg_status_img;
  logic [REG_W-1:0] reg_status_img;
  logic [REG_W-1:0] conv_status_img;

  // build readable status words regardless of mask
  always_comb begin
    chg_status_img = STATUS_RST;
    chg_status_img[CHG_LSB +: CHG_W] = charger_flags; // RULE_12
    reg_status_img = STATUS_RST;
    reg_status_img[REG_UV_LSB +: REG_UV_W] = regulator_undervolt_flags; // RULE_09
    conv_status_img = STATUS_RST;
    conv_status_img[CONV_UV_LSB +: CONV_UV_W] = converter_undervolt_flags; // RULE_10
    conv_status_img[CONV_HC_LSB] = conv1_overcurrent_flag; // RULE_06
    conv_status_img[CONV_HC_LSB+1] = conv2_overcurrent_flag; // RULE_06
  end

  // ------------------------------------------------------------
  // wishbone slave: decode and handshake
  // ------------------------------------------------------------
  logic req;
  logic commit_wr;
  logic ack_reg;
  logic ack_next;
  logic [WB_DAT_W-1:0] rdata_reg;
  logic [WB_DAT_W-1:0] rdata_next;
  logic [REG_W-1:0] wdata;
  logic [REG_W-1:0] lanes;

  // write takes effect on the edge where ack is seen high
  assign req = wb_cyc_in & wb_stb_in;
  assign commit_wr = req & wb_we_in & ack_reg;
  assign wdata = wb_dat_in[REG_W-1:0];
  assign lanes = lane_mask(wb_sel_in);

  // ------------------------------------------------------------
  // mask registers
  // ------------------------------------------------------------
  logic [REG_W-1:0] chg_mask_reg;
  logic [REG_W-1:0] chg_mask_next;
  logic [REG_W-1:0] reg_mask_reg;
  logic [REG_W-1:0] reg_mask_next;
  logic [REG_W-1:0] conv_mask_reg;
  logic [REG_W-1:0] conv_mask_next;

  // mask writes, only implemented bits stored
  always_comb begin
    chg_mask_next = chg_mask_reg;
    reg_mask_next = reg_mask_reg;
    conv_mask_next = conv_mask_reg;
    if (commit_wr && hit(wb_adr_in, IDX_CHG_MASK)) begin
      chg_mask_next = mask_merge(chg_mask_reg, wdata, lanes, CHG_MASK_RST); // RULE_11
    end
    if (commit_wr && hit(wb_adr_in, IDX_REG_MASK)) begin
      reg_mask_next = mask_merge(reg_mask_reg, wdata, lanes, REG_MASK_RST); // RULE_09
    end
    if (commit_wr && hit(wb_adr_in, IDX_CONV_MASK)) begin
      conv_mask_next = mask_merge(conv_mask_reg, wdata, lanes, CONV_MASK_RST); // RULE_07
    end
  end

  // register masks, all masked out of reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      chg_mask_reg <= CHG_MASK_RST; // RULE_03
      reg_mask_reg <= REG_MASK_RST; // RULE_03
      conv_mask_reg <= CONV_MASK_RST; // RULE_03
    end else begin
      chg_mask_reg <= chg_mask_next;
      reg_mask_reg <= reg_mask_next;
      conv_mask_reg <= conv_mask_next;
    end
  end

  // named mask fields
  logic [REG_UV_W-1:0] regulator_undervolt_masks;
  logic [CONV_UV_W-1:0] converter_undervolt_masks;
  logic conv1_overcurrent_mask;
  logic conv2_overcurrent_mask;
  logic battery_hot_mask;
  logic battery_cold_mask;
  logic battery_fail_mask;
  logic battery_overvolt_mask;
  logic charge_done_mask;
  logic charge_timeout_mask;
  logic charge_mode_change_mask;
  logic charge_begin_mask;

  assign regulator_undervolt_masks = reg_mask_reg[REG_UV_LSB +: REG_UV_W]; // RULE_09
  assign converter_undervolt_masks = conv_mask_reg[CONV_UV_LSB +: CONV_UV_W]; // RULE_10
  assign conv1_overcurrent_mask = conv_mask_reg[CONV_HC_LSB]; // RULE_07
  assign conv2_overcurrent_mask = conv_mask_reg[CONV_HC_LSB+1]; // RULE_07
  // charger masks, hot at the top down to start
  assign battery_hot_mask = chg_mask_reg[CHG_LSB+7]; // RULE_11
  assign battery_cold_mask = chg_mask_reg[CHG_LSB+6];
  assign battery_fail_mask = chg_mask_reg[CHG_LSB+5];
  assign battery_overvolt_mask = chg_mask_reg[CHG_LSB+4];
  assign charge_done_mask = chg_mask_reg[CHG_LSB+3];
  assign charge_timeout_mask = chg_mask_reg[CHG_LSB+2];
  assign charge_mode_change_mask = chg_mask_reg[CHG_LSB+1];
  assign charge_begin_mask = chg_mask_reg[CHG_LSB];

  // ------------------------------------------------------------
  // write-one-to-clear pulses into the bank
  // ------------------------------------------------------------
  logic [REG_W-1:0] w1c;

  // ones written on enabled lanes clear, zeros leave bits alone
  always_comb begin
    w1c = wdata & lanes; // RULE_04
    clear_vec = '0;
    if (commit_wr && hit(wb_adr_in, IDX_CHG_STATUS)) begin
      clear_vec[EV_CHG_LSB +: CHG_W] = w1c[CHG_LSB +: CHG_W]; // RULE_04
    end
    if (commit_wr && hit(wb_adr_in, IDX_REG_STATUS)) begin
      clear_vec[EV_REG_LSB +: REG_UV_W] = w1c[REG_UV_LSB +: REG_UV_W]; // RULE_04
    end
    if (commit_wr && hit(wb_adr_in, IDX_CONV_STATUS)) begin
      clear_vec[EV_UV_LSB +: CONV_UV_W] = w1c[CONV_UV_LSB +: CONV_UV_W]; // RULE_04
      clear_vec[EV_HC_LSB +: CONV_HC_W] = w1c[CONV_HC_LSB +: CONV_HC_W]; // RULE_04
    end
  end

  // ------------------------------------------------------------
  // primary interrupts
  // ------------------------------------------------------------
  logic chg_pri_next;
  logic hc_pri_next;
  logic uv_pri_next;
  logic chg_pri_reg;
  logic hc_pri_reg;
  logic uv_pri_reg;

  // a flag reaches its primary only while its mask is zero
  always_comb begin
    chg_pri_next = |(charger_flags & ~chg_mask_reg[CHG_LSB +: CHG_W]); // RULE_01
    hc_pri_next = (conv1_overcurrent_flag & ~conv1_overcurrent_mask) // RULE_05
                | (conv2_overcurrent_flag & ~conv2_overcurrent_mask); // RULE_01
    uv_pri_next = |(regulator_undervolt_flags & ~regulator_undervolt_masks) // RULE_08
                | |(converter_undervolt_flags & ~converter_undervolt_masks); // RULE_01
  end

  // register primaries, level follows flags and masks
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      chg_pri_reg <= 1'b0;
      hc_pri_reg <= 1'b0;
      uv_pri_reg <= 1'b0;
    end else begin
      chg_pri_reg <= chg_pri_next; // RULE_13
      hc_pri_reg <= hc_pri_next; // RULE_13
      uv_pri_reg <= uv_pri_next; // RULE_13
    end
  end

  assign charger_primary_irq_out = chg_pri_reg;
  assign high_current_primary_irq_out = hc_pri_reg;
  assign undervoltage_primary_irq_out = uv_pri_reg;
  // combined line high while any primary is up
  assign irq_out = chg_pri_reg | hc_pri_reg | uv_pri_reg;

  // ------------------------------------------------------------
  // read mux and ack
  // ------------------------------------------------------------
  logic [REG_W-1:0] rd_word;

  // select the register image, unmapped reads zero
  always_comb begin
    rd_word = '0;
    if (hit(wb_adr_in, IDX_CHG_STATUS)) begin
      rd_word = chg_status_img;
    end else if (hit(wb_adr_in, IDX_REG_STATUS)) begin
      rd_word = reg_status_img;
    end else if (hit(wb_adr_in, IDX_CONV_STATUS)) begin
      rd_word = conv_status_img;
    end else if (hit(wb_adr_in, IDX_CHG_MASK)) begin
      rd_word = chg_mask_reg;
    end else if (hit(wb_adr_in, IDX_REG_MASK)) begin
      rd_word = reg_mask_reg;
    end else if (hit(wb_adr_in, IDX_CONV_MASK)) begin
      rd_word = conv_mask_reg;
    end else if (hit(wb_adr_in, IDX_PRIMARY)) begin
      rd_word[PRI_CHG_BIT] = chg_pri_reg;
      rd_word[PRI_HC_BIT] = hc_pri_reg;
      rd_word[PRI_UV_BIT] = uv_pri_reg;
    end
  end

  // one-cycle ack after the request, dropped the cycle after
  always_comb begin
    ack_next = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (req && !ack_reg) begin
      rdata_next = {{(WB_DAT_W-REG_W){1'b0}}, rd_word};
    end
  end

  // register the bus answer
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;
endmodule // pmic_fault_interrupt_masking

`default_nettype wire

// ### pmic_irq_props.sv
// checker of bus handshake and interrupt causes for the fault block
`timescale 1ns/1ps
`default_nettype none
module pmic_irq_props
  import pmic_irq_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [WB_DAT_W-1:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [CONV_HC_W-1:0] converter_hc_in,
  input wire logic charger_primary_irq_out,
  input wire logic high_current_primary_irq_out,
  input wire logic undervoltage_primary_irq_out,
  input wire logic irq_out
);
  logic req;
  logic wr_ack;
  logic wrote_reg;
  logic wrote_next;
  logic [1:0] wr_hist_reg;
  logic [1:0] wr_hist_next;
  logic [1:0] hc_prev_reg;
  logic [7:0] hc_hist_reg;
  logic [7:0] hc_hist_next;

  // write commits and rising high-current inputs seen lately
  assign req = wb_cyc_in && wb_stb_in;
  assign wr_ack = wb_ack_out && wb_we_in;
  always_comb begin
    wrote_next = wrote_reg || wr_ack;
    wr_hist_next = {wr_hist_reg[0], wr_ack};
    hc_hist_next = {hc_hist_reg[6:0], |(converter_hc_in & ~hc_prev_reg)};
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wrote_reg <= 1'b0;
      wr_hist_reg <= 2'b00;
      hc_prev_reg <= 2'b00;
      hc_hist_reg <= 8'h00;
    end else begin
      wrote_reg <= wrote_next;
      wr_hist_reg <= wr_hist_next;
      hc_prev_reg <= converter_hc_in;
      hc_hist_reg <= hc_hist_next;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_req;
    req && !wb_ack_out;
  endsequence
  sequence s_ack_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  a_ack_answer: assert property (s_req |=> s_ack_pulse)
    else $error("request not answered by a single ack");
  a_ack_idle: assert property (!req |=> !wb_ack_out)
    else $error("ack without request");
  a_dat_upper: assert property (wb_dat_out[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_irq_merge: assert property (irq_out == (charger_primary_irq_out ||
    high_current_primary_irq_out || undervoltage_primary_irq_out))
    else $error("merged irq wrong");
  a_masked_reset: assert property (!wrote_reg |-> !(charger_primary_irq_out ||
    high_current_primary_irq_out || undervoltage_primary_irq_out))
    else $error("primary irq while all masked");
  a_hc_rise: assert property ($rose(high_current_primary_irq_out) |->
    (|hc_hist_reg[5:1]) || (|wr_hist_reg))
    else $error("high-current irq rose without cause");
  a_hc_fall: assert property ($fell(high_current_primary_irq_out) |-> |wr_hist_reg)
    else $error("high-current irq fell without write");
  a_uv_fall: assert property ($fell(undervoltage_primary_irq_out) |-> |wr_hist_reg)
    else $error("undervoltage irq fell without write");
  a_chg_fall: assert property ($fell(charger_primary_irq_out) |-> |wr_hist_reg)
    else $error("charger irq fell without write");
endmodule // pmic_irq_props

bind pmic_fault_interrupt_masking pmic_irq_props u_props (
  .clk_in(clk_in),
  .rst_b_in(rst_b_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .converter_hc_in(converter_hc_in),
  .charger_primary_irq_out(charger_primary_irq_out),
  .high_current_primary_irq_out(high_current_primary_irq_out),
  .undervoltage_primary_irq_out(undervoltage_primary_irq_out),
  .irq_out(irq_out)
);
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the fault interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pmic_irq_pkg::*;
;
  logic clk_in;
  logic rst_b_in;
  logic cyc, stb, we, ack, chg_irq, hc_irq, uv_irq, irq;
  logic [WB_ADR_W-1:0] adr;
  logic [WB_SEL_W-1:0] sel;
  logic [WB_DAT_W-1:0] wdat;
  logic [WB_DAT_W-1:0] rdat;
  logic [EV_W-1:0] ev;
  int err_count;
  int num_checks;
  int cycles;

  pmic_fault_interrupt_masking uut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .charger_event_in(ev[7:0]),
    .regulator_uv_in(ev[17:8]), .converter_uv_in(ev[21:18]),
    .converter_hc_in(ev[23:22]), .charger_primary_irq_out(chg_irq),
    .high_current_primary_irq_out(hc_irq), .undervoltage_primary_irq_out(uv_irq),
    .irq_out(irq)
  );

  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [IDX_W-1:0] idx, input logic [15:0] d,
                     input logic [3:0] s, output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[15:0];
    if (n >= 50) begin
      err_count++;
      $display("ERROR t=%0t ack got=%h exp=%h", $time, ack, 1'b1);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d,
                    input logic [3:0] s = 4'hf);
    logic [15:0] q;
    bus(1'b1, idx, d, s, q);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, 4'hf, q);
    check(q, exp);
  endtask

  // compares irq_out and the three primaries {uv, hc, chg}
  task automatic irqs(input logic [2:0] exp);
    check({12'h000, irq, uv_irq, hc_irq, chg_irq}, {12'h000, |exp, exp});
  endtask

  task give_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      $display("ERROR t=%0t cycles got=%h exp_below=%h", $time, cycles, 8000);
      give_verdict();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [IDX_W-1:0] sidx;
    logic [IDX_W-1:0] midx;
    logic [15:0] v;
    logic [2:0] pri;
    {cyc, stb, we, adr, sel, wdat, ev} = '0;
    rst_b_in = 1'b0;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(IDX_CHG_MASK, 16'hff00);
    rd(IDX_REG_MASK, 16'h03ff);
    rd(IDX_CONV_MASK, 16'h030f);
    rd(IDX_REG_STATUS, 16'h0000);
    wr(16'h4015, 16'hffff);
    rd(16'h4015, 16'h0000);
    irqs(3'b000);
    $display("test reset values done");
    for (int i = 0; i < EV_W; i++) begin
      if (i < 8) begin
        {sidx, midx, v, pri} = {IDX_CHG_STATUS, IDX_CHG_MASK, 16'h0100 << i, 3'b001};
      end else if (i < 18) begin
        {sidx, midx, v, pri} = {IDX_REG_STATUS, IDX_REG_MASK, 16'h0001 << (i - 8), 3'b100};
      end else if (i < 22) begin
        {sidx, midx, v, pri} = {IDX_CONV_STATUS, IDX_CONV_MASK, 16'h0001 << (i - 18), 3'b100};
      end else begin
        {sidx, midx, v, pri} = {IDX_CONV_STATUS, IDX_CONV_MASK, 16'h0100 << (i - 22), 3'b010};
      end
      ev[i] <= 1'b1;
      repeat (6) @(posedge clk_in);
      rd(sidx, v);
      irqs(3'b000);
      wr(sidx, 16'h0000);
      rd(sidx, v);
      wr(midx, v);
      repeat (2) @(posedge clk_in);
      irqs(3'b000);
      wr(midx, ~v);
      repeat (2) @(posedge clk_in);
      irqs(pri);
      rd(IDX_PRIMARY, {13'h0000, pri});
      wr(sidx, v);
      repeat (2) @(posedge clk_in);
      irqs(3'b000);
      rd(IDX_PRIMARY, 16'h0000);
      rd(sidx, 16'h0000);
      ev[i] <= 1'b0;
      wr(midx, 16'hffff);
    end
    rd(IDX_CONV_MASK, 16'h030f);
    $display("test event walk done");
    wr(IDX_CONV_MASK, 16'h0000, 4'h1);
    rd(IDX_CONV_MASK, 16'h0300);
    ev[22] <= 1'b1;
    repeat (6) @(posedge clk_in);
    ev[22] <= 1'b0;
    repeat (4) @(posedge clk_in);
    ev[22] <= 1'b1;
    @(posedge clk_in);
    wr(IDX_CONV_STATUS, 16'h0100);
    rd(IDX_CONV_STATUS, 16'h0100);
    ev[22] <= 1'b0;
    wr(IDX_CONV_STATUS, 16'h0100);
    rd(IDX_CONV_STATUS, 16'h0000);
    $display("test lanes and set priority done");
    rst_b_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(IDX_CONV_MASK, 16'h030f);
    $display("test second reset done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
